// ===== rtl/pot_regs_params.svh
// constants for the quad pot register bank: offsets, field positions,
// reset values and timing figures; assumes inclusion by the top module only
`ifndef POT_REGS_PARAMS_SVH
`define POT_REGS_PARAMS_SVH

// address byte decode
`define POT_SEL_ADDR 3'h7
`define POT_LAST_CH 3'h3
// select register fields
`define POT_SEL_NV_BIT 0
`define POT_SEL_ROW_LO 1
`define POT_SEL_ROW_HI 2
`define POT_SEL_RESET 3'h0
// slave address fields
`define POT_ID_LSB 4
`define POT_HW_LSB 1
`define POT_RW_BIT 0
// bit position of the acknowledge slot within a byte frame
`define POT_ACK_SLOT 4'h8
// reset contents
`define POT_WIPER_RESET 8'h00
`define POT_STORED_RESET 8'h00
// nonvolatile write cycle
`define POT_NV_TIME_US 5000
`define POT_REF_CLK_MHZ 100

`endif

// ===== rtl/pot_regs_pkg.sv
// types shared by the quad pot register bank
// assumes the params header sits beside it in rtl/
package pot_regs_pkg;
  // gray along idle -> addr -> reg -> data, read and skip off the side
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_ADDR = 3'h1,
    S_REG  = 3'h3,
    S_DATA = 3'h2,
    S_READ = 3'h6,
    S_SKIP = 3'h7
  } link_state_t;
  typedef logic [7:0] pot_byte_t;
endpackage

// ===== rtl/pot_reg_access.sv
// quad pot register bank behind a 2-wire serial slave port
// assumes scl_clk is the host's serial clock, sda is open drain and the
// board resolves it from sda_oe; ref_clk runs at 100 MHz
`timescale 1ns/1ns
`default_nettype none
`include "pot_regs_params.svh"

// Function
// - four channels, each one wiper register and four stored registers
// - registers form five pages of four: wipers plus one per row
// - reading or writing a stored register also loads that channel's wiper
// - select register sits at address 07h and clears to 00h
// - select holds row high bit2, row low bit1, nonvolatile bit0
// - nonvolatile bit low targets wipers, high targets stored row
// - writing 1, 3, 5 or 7 points later accesses at that row
// - select write with the nonvolatile bit set recalls its row into all wipers
// - wiper write changes only the addressed channel
// - address 0..3 picks a channel, 4..6 unused, 7 select register
// - byte write is slave address, address, data, stop; all acknowledged
// - volatile writes leave no busy period after stop
// - stored register write starts nonvolatile cycle at stop if protect high
// - during the cycle requests are ignored and data line released
// - stored write also reloads every wiper from that row
// - target depends on select bits, protect pin and channel address
// - nonvolatile cycle lasts 5 ms and ignores all commands
// - while busy the slave address is not acknowledged
// - protect pin low at stop discards the stored write
module pot_reg_access #(
  parameter logic [3:0] DEV_TYPE_ID = 4'hA, // arbitrary value
  parameter int NV_CYCLES = `POT_NV_TIME_US * `POT_REF_CLK_MHZ,
  parameter int CHANNELS = 4,
  parameter int ROWS = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic wp_n,
  input wire logic [2:0] hw_addr,
  output logic nv_busy,
  output pot_regs_pkg::pot_byte_t wiper_pos0,
  output pot_regs_pkg::pot_byte_t wiper_pos1,
  output pot_regs_pkg::pot_byte_t wiper_pos2,
  output pot_regs_pkg::pot_byte_t wiper_pos3
);
  import pot_regs_pkg::*;

  localparam int CW = $clog2(NV_CYCLES + 1);

  if (CHANNELS != 4 || ROWS != 4 || NV_CYCLES < 1) begin : g_check
    $error("pot_reg_access: four channels, four rows and a nonzero cycle only");
  end

  // ----------------------------------------------------------------
  // link domain: bit capture on the host's clock
  // ----------------------------------------------------------------
  logic link_rst_ff;
  logic [3:0] lbits_ff, nxt_lbits;
  pot_byte_t lshift_ff, nxt_lshift;
  pot_byte_t lbyte_ff, nxt_lbyte;
  logic ltgl_ff, nxt_ltgl;

  always_comb begin
    nxt_lbits = (lbits_ff == `POT_ACK_SLOT) ? 4'h0 : lbits_ff + 4'h1;
    nxt_lshift = {lshift_ff[6:0], sda_in};
    nxt_lbyte = lbyte_ff;
    nxt_ltgl = ltgl_ff;
    if (lbits_ff == 4'h7) begin
      nxt_lbyte = nxt_lshift;
      nxt_ltgl = ~ltgl_ff;
    end
  end

  // held in reset from each start or stop until scl falls, so the frame
  // counter never depends on an scl edge outside the frame
  always_ff @(posedge scl_clk or posedge link_rst_ff) begin
    if (link_rst_ff) begin
      lbits_ff <= 4'h0;
      lshift_ff <= 8'h00;
      lbyte_ff <= 8'h00;
      ltgl_ff <= 1'b0;
    end else begin
      lbits_ff <= nxt_lbits;
      lshift_ff <= nxt_lshift;
      lbyte_ff <= nxt_lbyte;
      ltgl_ff <= nxt_ltgl;
    end
  end

  // ----------------------------------------------------------------
  // pin and crossing synchronisers
  // ----------------------------------------------------------------
  logic scl_m_ff, scl_s_ff, scl_d_ff;
  logic sda_m_ff, sda_s_ff, sda_d_ff;
  logic tgl_m_ff, tgl_s_ff, tgl_d_ff;
  logic wp_m_ff, wp_s_ff;
  logic [2:0] hw_m_ff, hw_s_ff;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
      {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
      {tgl_m_ff, tgl_s_ff, tgl_d_ff} <= 3'h0;
      {wp_m_ff, wp_s_ff} <= 2'h0;
      hw_m_ff <= 3'h0;
      hw_s_ff <= 3'h0;
    end else begin
      {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_clk, scl_m_ff, scl_s_ff};
      {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
      {tgl_m_ff, tgl_s_ff, tgl_d_ff} <= {ltgl_ff, tgl_m_ff, tgl_s_ff};
      {wp_m_ff, wp_s_ff} <= {wp_n, wp_m_ff};
      hw_m_ff <= hw_addr;
      hw_s_ff <= hw_m_ff;
    end
  end

  logic rise_ev, fall_ev, start_ev, stop_ev, byte_ev;
  assign rise_ev = scl_s_ff & ~scl_d_ff;
  assign fall_ev = ~scl_s_ff & scl_d_ff;
  assign start_ev = scl_s_ff & scl_d_ff & sda_d_ff & ~sda_s_ff;
  assign stop_ev = scl_s_ff & scl_d_ff & ~sda_d_ff & sda_s_ff;
  // lbyte_ff is stable for a whole byte after its toggle
  assign byte_ev = tgl_s_ff ^ tgl_d_ff;

  // ----------------------------------------------------------------
  // register bank and protocol control
  // ----------------------------------------------------------------
  link_state_t st_ff, nxt_st;
  logic [3:0] rcnt_ff, nxt_rcnt;
  logic ack_ff, nxt_ack;
  logic oe_ff, nxt_oe;
  logic nxt_link_rst;
  pot_byte_t tx_ff, nxt_tx;
  logic [2:0] ptr_ff, nxt_ptr;
  logic [2:0] sel_ff, nxt_sel;
  logic pend_ff, nxt_pend;
  pot_byte_t pend_data_ff, nxt_pend_data;
  logic [1:0] pend_ch_ff, nxt_pend_ch;
  logic [1:0] pend_row_ff, nxt_pend_row;
  logic [CW-1:0] busy_cnt_ff, nxt_busy_cnt;
  pot_byte_t wiper_ff [4];
  pot_byte_t nxt_wiper [4];
  pot_byte_t stored_ff [4][4];
  pot_byte_t nxt_stored [4][4];
  logic busy, load_rd, sel_wr_ev, wcr_wr_ev;

  assign busy = |busy_cnt_ff;

  function automatic logic [1:0] row_of(input logic [2:0] sel);
    row_of = {sel[`POT_SEL_ROW_HI], sel[`POT_SEL_ROW_LO]};
  endfunction

  function automatic logic is_channel(input logic [2:0] ptr);
    is_channel = (ptr <= `POT_LAST_CH);
  endfunction

  always_comb begin
    nxt_st = st_ff;
    nxt_rcnt = rcnt_ff;
    nxt_ack = ack_ff;
    nxt_oe = oe_ff;
    nxt_link_rst = link_rst_ff;
    nxt_tx = tx_ff;
    nxt_ptr = ptr_ff;
    nxt_sel = sel_ff;
    nxt_pend = pend_ff;
    nxt_pend_data = pend_data_ff;
    nxt_pend_ch = pend_ch_ff;
    nxt_pend_row = pend_row_ff;
    nxt_busy_cnt = busy ? busy_cnt_ff - CW'(1) : busy_cnt_ff;
    nxt_wiper = wiper_ff;
    nxt_stored = stored_ff;
    load_rd = 1'b0;
    sel_wr_ev = 1'b0;
    wcr_wr_ev = 1'b0;

    if (!scl_s_ff) begin
      nxt_link_rst = 1'b0;
    end
    if (rise_ev) begin
      nxt_rcnt = (rcnt_ff == `POT_ACK_SLOT) ? 4'h0 : rcnt_ff + 4'h1;
      // host acknowledge decides whether another read byte follows
      if (st_ff == S_READ && rcnt_ff == `POT_ACK_SLOT && !ack_ff) begin
        if (sda_s_ff) begin
          nxt_st = S_SKIP;
        end else begin
          load_rd = 1'b1;
        end
      end
    end
    if (fall_ev) begin
      nxt_oe = 1'b0;
      if (rcnt_ff == `POT_ACK_SLOT) begin
        nxt_oe = ack_ff;
      end else if (rcnt_ff == 4'h0) begin
        nxt_ack = 1'b0;
      end
      if (st_ff == S_READ && rcnt_ff < `POT_ACK_SLOT) begin
        nxt_oe = ~tx_ff[7];
        nxt_tx = {tx_ff[6:0], 1'b0};
      end
    end

    if (byte_ev) begin
      case (st_ff)
        S_ADDR: begin
          if (lbyte_ff[7:`POT_ID_LSB] == DEV_TYPE_ID &&
              lbyte_ff[`POT_ID_LSB-1:`POT_HW_LSB] == hw_s_ff && !busy) begin
            nxt_ack = 1'b1;
            nxt_st = lbyte_ff[`POT_RW_BIT] ? S_READ : S_REG;
            load_rd = lbyte_ff[`POT_RW_BIT];
          end else begin
            nxt_st = S_SKIP;
          end
        end
        S_REG: begin
          // upper address bits are not decoded
          nxt_ptr = lbyte_ff[2:0];
          nxt_ack = 1'b1;
          nxt_st = S_DATA;
        end
        S_DATA: begin
          nxt_ack = 1'b1;
          if (ptr_ff == `POT_SEL_ADDR) begin
            sel_wr_ev = 1'b1;
            nxt_sel = lbyte_ff[2:0];
            if (lbyte_ff[`POT_SEL_NV_BIT]) begin
              for (int c = 0; c < 4; c++) begin
                nxt_wiper[c] = stored_ff[row_of(lbyte_ff[2:0])][c];
              end
            end
          end else if (is_channel(ptr_ff)) begin
            // nonvolatile bit picks wiper or stored row
            if (!sel_ff[`POT_SEL_NV_BIT]) begin
              wcr_wr_ev = 1'b1;
              nxt_wiper[ptr_ff[1:0]] = lbyte_ff;
            end else begin
              // row held from the last select write
              nxt_pend = 1'b1;
              nxt_pend_data = lbyte_ff;
              nxt_pend_ch = ptr_ff[1:0];
              nxt_pend_row = row_of(sel_ff);
            end
          end
        end
        default: begin
        end
      endcase
    end

    if (load_rd) begin
      if (ptr_ff == `POT_SEL_ADDR) begin
        nxt_tx = {5'h00, sel_ff};
      end else if (!is_channel(ptr_ff)) begin
        nxt_tx = 8'h00;
      end else if (!sel_ff[`POT_SEL_NV_BIT]) begin
        nxt_tx = wiper_ff[ptr_ff[1:0]];
      end else begin
        // a stored read moves into its wiper
        nxt_tx = stored_ff[row_of(sel_ff)][ptr_ff[1:0]];
        nxt_wiper[ptr_ff[1:0]] = nxt_tx;
      end
    end

    if (stop_ev) begin
      nxt_st = S_IDLE;
      nxt_oe = 1'b0;
      nxt_link_rst = 1'b1;
      nxt_pend = 1'b0;
      // protect pin gates the stored target
      if (pend_ff && !busy && wp_s_ff) begin
        nxt_busy_cnt = CW'(NV_CYCLES);
        nxt_stored[pend_row_ff][pend_ch_ff] = pend_data_ff;
        for (int c = 0; c < 4; c++) begin
          nxt_wiper[c] = nxt_stored[pend_row_ff][c];
        end
      end
    end
    if (start_ev) begin
      // a repeated start abandons any unfinished stored write
      nxt_st = S_ADDR;
      nxt_rcnt = 4'h0;
      nxt_ack = 1'b0;
      nxt_oe = 1'b0;
      nxt_link_rst = 1'b1;
      nxt_pend = 1'b0;
    end
    // line released for the whole cycle
    if (busy) begin
      nxt_oe = 1'b0;
    end
  end

  // four wipers plus four rows of four stored registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= S_IDLE;
      rcnt_ff <= 4'h0;
      ack_ff <= 1'b0;
      oe_ff <= 1'b0;
      link_rst_ff <= 1'b1;
      tx_ff <= 8'h00;
      ptr_ff <= 3'h0;
      sel_ff <= `POT_SEL_RESET;
      pend_ff <= 1'b0;
      pend_data_ff <= 8'h00;
      pend_ch_ff <= 2'h0;
      pend_row_ff <= 2'h0;
      busy_cnt_ff <= '0;
      for (int c = 0; c < 4; c++) begin
        wiper_ff[c] <= `POT_WIPER_RESET;
        for (int r = 0; r < 4; r++) begin
          stored_ff[r][c] <= `POT_STORED_RESET;
        end
      end
    end else begin
      st_ff <= nxt_st;
      rcnt_ff <= nxt_rcnt;
      ack_ff <= nxt_ack;
      oe_ff <= nxt_oe;
      link_rst_ff <= nxt_link_rst;
      tx_ff <= nxt_tx;
      ptr_ff <= nxt_ptr;
      sel_ff <= nxt_sel;
      pend_ff <= nxt_pend;
      pend_data_ff <= nxt_pend_data;
      pend_ch_ff <= nxt_pend_ch;
      pend_row_ff <= nxt_pend_row;
      busy_cnt_ff <= nxt_busy_cnt;
      wiper_ff <= nxt_wiper;
      stored_ff <= nxt_stored;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;
  assign nv_busy = busy;
  assign wiper_pos0 = wiper_ff[0];
  assign wiper_pos1 = wiper_ff[1];
  assign wiper_pos2 = wiper_ff[2];
  assign wiper_pos3 = wiper_ff[3];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ack_slot;
    fall_ev && rcnt_ff == `POT_ACK_SLOT && ack_ff && !busy;
  endsequence
  sequence s_nv_commit;
    stop_ev && pend_ff && !busy && wp_s_ff;
  endsequence

  a_ack_driven: assert property (s_ack_slot |=> sda_oe)
    else $error("acknowledge slot not driven");
  a_busy_quiet: assert property (nv_busy |=> !sda_oe)
    else $error("data line driven during nonvolatile cycle");
  a_nv_start: assert property (s_nv_commit |=> nv_busy [*8])
    else $error("nonvolatile cycle did not start");
  a_busy_no_ack: assert property (
    (byte_ev && st_ff == S_ADDR && busy) |=> !ack_ff && st_ff == S_SKIP)
    else $error("slave address acknowledged while busy");
  a_wp_discard: assert property (
    (stop_ev && pend_ff && !busy && !wp_s_ff) |=> !nv_busy && !pend_ff)
    else $error("stored write not discarded with protect low");
  a_vol_no_busy: assert property (
    (stop_ev && !pend_ff && !busy) |=> !nv_busy)
    else $error("busy period after volatile write");
  a_wiper_only: assert property (
    (wcr_wr_ev && ptr_ff == 3'h0) |=>
      wiper_ff[0] == $past(lbyte_ff) && wiper_ff[1] == $past(wiper_ff[1]))
    else $error("wiper write touched another channel");
  a_row_recall: assert property (
    (sel_wr_ev && lbyte_ff[2:0] == 3'h3) |=> wiper_ff[2] == $past(stored_ff[1][2]))
    else $error("select write did not recall row");
  a_sel_zero: assert property (
    (load_rd && ptr_ff == `POT_SEL_ADDR) |=> tx_ff[7:3] == 5'h00)
    else $error("reserved select bits read nonzero");
  a_nv_length: assert property (
    $rose(nv_busy) |-> busy_cnt_ff == CW'(NV_CYCLES))
    else $error("nonvolatile cycle length wrong");
endmodule
`default_nettype wire

// ===== sim/pot_bus_host.sv
// behavioural 2-wire bus host for the pot register bank
// assumes the bench resolves the open-drain data line with a pull-up
`timescale 1ns/1ns
`default_nettype none
module pot_bus_host (
  output logic scl_clk,
  output logic sda_low,
  input wire logic sda_line
);
  // ----------------------------------------
  // bit level
  // ----------------------------------------
  // 30 ns tick; low phases of three ticks leave room for the
  // device's two-flop synchronisers before the line is sampled
  initial begin
    scl_clk = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bus_start();
    sda_low = 1'b0;
    #60 scl_clk = 1'b1;
    #60 sda_low = 1'b1;
    #60 scl_clk = 1'b0;
  endtask
  task automatic bus_stop();
    sda_low = 1'b1;
    #90 scl_clk = 1'b1;
    #60 sda_low = 1'b0;
    #60;
  endtask
  task automatic put_bit(input logic b);
    sda_low = !b;
    #90 scl_clk = 1'b1;
    #60 scl_clk = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    sda_low = 1'b0;
    #90 scl_clk = 1'b1;
    #30 b = sda_line;
    #30 scl_clk = 1'b0;
  endtask
  // ----------------------------------------
  // byte level
  // ----------------------------------------
  // msb first, acknowledge slot
  task automatic put_byte(input logic [7:0] d, output logic acked);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    acked = !b;
  endtask
  // last byte of a read is answered with a nack
  task automatic get_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(last);
  endtask
endmodule
`default_nettype wire

// ===== sim/quad_pot_register_access_bench.sv
// self-checking bench for the quad pot register bank
// assumes the design's package and params header are compiled first
`timescale 1ns/1ns
`default_nettype none
module quad_pot_register_access_bench;
  import pot_regs_pkg::*;
  localparam logic [3:0] TYPE_ID = 4'hA; // arbitrary value
  localparam logic [2:0] HW = 3'h5;
  localparam int NV_LEN = 400;
  logic ref_clk, sys_rst, wp_n, ok;
  wire logic scl_clk, sda_line, sda_out, sda_oe, nv_busy, host_low;
  pot_byte_t w [4];
  pot_byte_t d;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  // ----------------------------------------
  // wiring
  // ----------------------------------------
  assign sda_line = (sda_oe ? sda_out : 1'b1) & !host_low;
  pot_reg_access #(.DEV_TYPE_ID(TYPE_ID), .NV_CYCLES(NV_LEN)) i_pot_reg_access (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .scl_clk(scl_clk), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .wp_n(wp_n), .hw_addr(HW), .nv_busy(nv_busy),
    .wiper_pos0(w[0]), .wiper_pos1(w[1]), .wiper_pos2(w[2]), .wiper_pos3(w[3]));
  pot_bus_host i_pot_bus_host (.scl_clk(scl_clk), .sda_low(host_low), .sda_line(sda_line));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = !ref_clk;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic conclude();
    $display("compared %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a hang past the expected run length counts as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wipers(input logic [31:0] exp);
    for (int i = 0; i < 4; i++) begin
      check("wiper", exp[8*i +: 8], w[i]);
    end
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic a0, a1, a2;
    i_pot_bus_host.bus_start();
    i_pot_bus_host.put_byte({TYPE_ID, HW, 1'b0}, a0);
    i_pot_bus_host.put_byte(addr, a1);
    i_pot_bus_host.put_byte(data, a2);
    i_pot_bus_host.bus_stop();
    ok = a0 & a1 & a2;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] q);
    logic a;
    i_pot_bus_host.bus_start();
    i_pot_bus_host.put_byte({TYPE_ID, HW, 1'b0}, a);
    i_pot_bus_host.put_byte(addr, a);
    i_pot_bus_host.bus_start();
    i_pot_bus_host.put_byte({TYPE_ID, HW, 1'b1}, a);
    i_pot_bus_host.get_byte(1'b1, q);
    i_pot_bus_host.bus_stop();
  endtask
  task automatic poll(input logic [2:0] hw);
    i_pot_bus_host.bus_start();
    i_pot_bus_host.put_byte({TYPE_ID, hw, 1'b0}, ok);
    i_pot_bus_host.bus_stop();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    wipers(32'h0000_0000);
    rd(8'h07, d);
    check("select", 8'h00, d);
    $display("done: reset values");
  endtask
  task automatic t_wiper();
    wr(8'h02, 8'h3A);
    check("ack", 8'h01, {7'h00, ok});
    wipers(32'h003A_0000);
    wr(8'h00, 8'h11);
    check("ack", 8'h01, {7'h00, ok});
    wipers(32'h003A_0011);
    check("busy", 8'h00, {7'h00, nv_busy});
    $display("done: wiper writes");
  endtask
  task automatic t_stored();
    wr(8'h07, 8'h03);
    wipers(32'h0000_0000);
    wr(8'h02, 8'h5C);
    check("busy", 8'h01, {7'h00, nv_busy});
    wipers(32'h005C_0000);
    poll(HW);
    check("busy ack", 8'h00, {7'h00, ok});
    for (int i = 0; i < 1000 && nv_busy !== 1'b0; i++) @(posedge ref_clk);
    poll(HW);
    check("idle ack", 8'h01, {7'h00, ok});
    $display("done: stored write");
  endtask
  task automatic t_protect();
    @(posedge ref_clk) wp_n <= 1'b0;
    wr(8'h01, 8'h77);
    check("busy", 8'h00, {7'h00, nv_busy});
    wipers(32'h005C_0000);
    @(posedge ref_clk) wp_n <= 1'b1;
    rd(8'h01, d);
    check("row1 ch1", 8'h00, d);
    $display("done: protected write");
  endtask
  task automatic t_rows();
    wr(8'h07, 8'h05);
    wipers(32'h0000_0000);
    rd(8'h02, d);
    check("row2 ch2", 8'h00, d);
    wr(8'h07, 8'h03);
    wipers(32'h005C_0000);
    rd(8'h02, d);
    check("row1 ch2", 8'h5C, d);
    $display("done: row select");
  endtask
  task automatic t_select();
    wr(8'h07, 8'hFF);
    rd(8'h07, d);
    check("select", 8'h07, d);
    wr(8'h05, 8'hAA);
    check("ack", 8'h01, {7'h00, ok});
    rd(8'h07, d);
    check("select", 8'h07, d);
    wr(8'h07, 8'h06);
    wr(8'h03, 8'h44);
    wipers(32'h4400_0000);
    poll(~HW);
    check("wrong hw ack", 8'h00, {7'h00, ok});
    wr(8'h07, 8'h00);
    wipers(32'h4400_0000);
    $display("done: select register");
  endtask
  initial begin
    sys_rst = 1'b1;
    wp_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_wiper();
    t_stored();
    t_protect();
    t_rows();
    t_select();
    conclude();
  end
endmodule
`default_nettype wire
